/* hw/crs_pkg.sv */
// Constants shared by the CPU register set block
package crs_pkg;
  // Register byte addresses on the bus
  localparam logic [7:0]  OFS_IP      = 8'h00;
  localparam logic [7:0]  OFS_LHS     = 8'h04;
  localparam logic [7:0]  OFS_RHS     = 8'h08;
  localparam logic [7:0]  OFS_IDX     = 8'h0c;
  localparam logic [7:0]  OFS_FAR     = 8'h10;
  localparam logic [7:0]  OFS_STK     = 8'h14;
  localparam logic [7:0]  OFS_STATUS  = 8'h18;
  localparam logic [7:0]  OFS_STATE   = 8'h1c;
  // Reset values
  localparam logic [15:0] IP_RESET    = 16'hfffd;
  localparam logic [7:0]  BANK_SEL_RESET = 8'h00;
  localparam logic [7:0]  FLAGS_RESET    = 8'h30;
  // Condition flag bit positions
  localparam int          BIT_H       = 7;
  localparam int          BIT_I       = 6;
  localparam int          BIT_LVL_HI  = 5;
  localparam int          BIT_LVL_LO  = 4;
  localparam int          BIT_N       = 3;
  localparam int          BIT_Z       = 2;
  localparam int          BIT_V       = 1;
  localparam int          BIT_C       = 0;
  // Interrupt level codes
  localparam logic [1:0]  IL_TOP      = 2'h0;
  localparam logic [1:0]  IL_BLANK    = 2'h1;
  // General register bank base in data memory
  localparam logic [15:0] GP_BASE     = 16'h0100;
  localparam int          BANK_BITS   = 5;
  // Width of the bus address
  localparam int          AW          = 8;
endpackage

/* hw/crs_core.sv */
// CPU dedicated register set, condition flags and interrupt gate
//
// Contract
// - Instruction pointer 16 bits, reset to fffd
// - Primary accumulator 16 bits, low byte for bytes
// - Second accumulator is other operand, low byte
// - Index, far, stack pointers unreset 16 bits
// - Status word: bank selector high, flags low
// - Reset clears enable, sets level bits 11
// - Half carry from bit 3 to 4
// - Interrupts accepted only while enable set
// - Service only when request outranks held level
// - Negative flag copies result top bit
// - Zero flag set on zero result
// - Overflow flag on two's complement overflow
// - Carry flag from bit 7 carry or borrow
// - Shift loads carry with shifted out bit
// - Byte registers banked eight per bank, 32
`timescale 1ns/1ps
module crs_core (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          reset_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Decoder side: pointer stepping
  input  wire logic          ip_step,
  input  wire logic          ip_load,
  input  wire logic [15:0]   ip_value,
  // ALU side: byte operation on the accumulators
  input  wire logic          alu_go,
  input  wire logic          alu_sub,
  input  wire logic          alu_shift,
  // Interrupt request
  input  wire logic          irq_req,
  input  wire logic [1:0]    irq_req_level,
  // General register select
  input  wire logic [2:0]    reg_num,
  // Block state out
  output logic [15:0]        instr_pointer,
  output logic [15:0]        status_word,
  output logic [15:0]        gp_addr,
  output logic               irq_take
);

  // Whole state of the block
  typedef struct packed {
    logic [15:0] ip;       // Instruction pointer
    logic [15:0] lhs;      // Primary accumulator
    logic [15:0] rhs;      // Second accumulator
    logic [15:0] idx;      // Index base
    logic [15:0] far;      // Far pointer
    logic [15:0] stk;      // Stack top
    logic [7:0]  bank_select; // Bank selector
    logic [7:0]  cond_flags;  // Condition flags
    logic [15:0] gpa;      // General register address
    logic        take;     // Interrupt accepted
    logic [31:0] rdata;    // Bus read data
    logic        rdy;      // Bus ready
    logic        err;      // Bus error
  } crs_state_type;

  crs_state_type s_r;      // Registered state
  crs_state_type s_nxt;    // Next state

  // Bus phase decode
  logic        setup_ph;   // Setup cycle
  logic        access_ok;  // Access completes this edge
  logic        wr_now;     // Write takes effect
  logic        mapped;     // Address hits a register
  // ALU byte operands and result
  logic [7:0]  opa;        // Left operand byte
  logic [7:0]  opb;        // Right operand byte
  logic [8:0]  wide;       // Result with carry out
  logic [7:0]  res;        // Result byte
  logic        half;       // Carry between nibbles
  logic        ovf;        // Signed overflow
  logic [1:0]  eff_il;     // Held level after merge

  // Bus decode
  assign setup_ph  = psel && !penable;
  assign access_ok = psel && penable && s_r.rdy;
  assign wr_now    = access_ok && pwrite && !s_r.err;
  assign mapped    = (paddr == crs_pkg::OFS_IP) || (paddr == crs_pkg::OFS_LHS) ||
                     (paddr == crs_pkg::OFS_RHS) || (paddr == crs_pkg::OFS_IDX) ||
                     (paddr == crs_pkg::OFS_FAR) || (paddr == crs_pkg::OFS_STK) ||
                     (paddr == crs_pkg::OFS_STATUS) || (paddr == crs_pkg::OFS_STATE);

  // Byte arithmetic on the accumulator low bytes
  always_comb begin
    opa = s_r.lhs[7:0];
    opb = s_r.rhs[7:0];
    if (alu_shift) begin
      // Left shift, top bit falls out
      wide = {opa, 1'b0};
      half = 1'b0;
      ovf  = 1'b0;
    end else if (alu_sub) begin
      // Borrow shows in the ninth bit
      wide = {1'b0, opa} - {1'b0, opb};
      half = (opa[3:0] < opb[3:0]);
      ovf  = (opa[7] != opb[7]) && (wide[7] != opa[7]);
    end else begin
      wide = {1'b0, opa} + {1'b0, opb};
      half = ({1'b0, opa[3:0]} + {1'b0, opb[3:0]}) > 5'h0f;
      ovf  = (opa[7] == opb[7]) && (wide[7] != opa[7]);
    end
    res = wide[7:0];
  end

  // Interrupt level merge
  always_comb begin
    eff_il = {s_r.cond_flags[crs_pkg::BIT_LVL_HI], s_r.cond_flags[crs_pkg::BIT_LVL_LO]};
    if (eff_il == crs_pkg::IL_BLANK) begin
      eff_il = crs_pkg::IL_TOP;
    end
  end

  // Next state
  always_comb begin
    s_nxt = s_r;
    // Pointer stepping from the decoder
    if (ip_load) begin
      s_nxt.ip = ip_value;
    end else if (ip_step) begin
      s_nxt.ip = s_r.ip + 16'h0001;
    end
    // Flag update from a byte operation
    if (alu_go) begin
      s_nxt.lhs[7:0] = res;
      s_nxt.cond_flags[crs_pkg::BIT_N] = res[7];
      s_nxt.cond_flags[crs_pkg::BIT_Z] = (res == 8'h00);
      s_nxt.cond_flags[crs_pkg::BIT_C] = wide[8];
      if (!alu_shift) begin
        s_nxt.cond_flags[crs_pkg::BIT_H] = half;
        s_nxt.cond_flags[crs_pkg::BIT_V] = ovf;
      end
    end
    s_nxt.take = irq_req && s_r.cond_flags[crs_pkg::BIT_I] && (irq_req_level < eff_il);
    s_nxt.gpa = crs_pkg::GP_BASE +
                {5'h00, s_r.bank_select[crs_pkg::BANK_BITS-1:0], reg_num};
    // Bus answer prepared in the setup cycle
    s_nxt.rdy = 1'b0;
    if (setup_ph) begin
      s_nxt.rdy   = 1'b1;
      s_nxt.err   = !mapped;
      s_nxt.rdata = 32'h0000_0000;
      case (paddr)
        crs_pkg::OFS_IP:     s_nxt.rdata[15:0] = s_r.ip;
        crs_pkg::OFS_LHS:    s_nxt.rdata[15:0] = s_r.lhs;
        crs_pkg::OFS_RHS:    s_nxt.rdata[15:0] = s_r.rhs;
        crs_pkg::OFS_IDX:    s_nxt.rdata[15:0] = s_r.idx;
        crs_pkg::OFS_FAR:    s_nxt.rdata[15:0] = s_r.far;
        crs_pkg::OFS_STK:    s_nxt.rdata[15:0] = s_r.stk;
        crs_pkg::OFS_STATUS: s_nxt.rdata[15:0] = {s_r.bank_select, s_r.cond_flags};
        crs_pkg::OFS_STATE:  s_nxt.rdata[15:0] = {s_r.take, eff_il, 13'h0000};
        default:             s_nxt.rdata = 32'h0000_0000;
      endcase
    end else if (access_ok) begin
      s_nxt.err = 1'b0;
    end
    // Software write wins over core updates
    if (wr_now) begin
      case (paddr)
        crs_pkg::OFS_IP:     s_nxt.ip  = pwdata[15:0];
        crs_pkg::OFS_LHS:    s_nxt.lhs = pwdata[15:0];
        crs_pkg::OFS_RHS:    s_nxt.rhs = pwdata[15:0];
        crs_pkg::OFS_IDX:    s_nxt.idx = pwdata[15:0];
        crs_pkg::OFS_FAR:    s_nxt.far = pwdata[15:0];
        crs_pkg::OFS_STK:    s_nxt.stk = pwdata[15:0];
        crs_pkg::OFS_STATUS: begin
          s_nxt.bank_select = pwdata[15:8];
          s_nxt.cond_flags  = pwdata[7:0];
        end
        default: begin
          s_nxt.err = 1'b0;
        end
      endcase
    end
    // Synchronous reset; data registers keep no reset
    if (!reset_n) begin
      s_nxt.ip    = crs_pkg::IP_RESET;
      s_nxt.bank_select = crs_pkg::BANK_SEL_RESET;
      s_nxt.cond_flags  = crs_pkg::FLAGS_RESET;
      s_nxt.gpa   = crs_pkg::GP_BASE;
      s_nxt.take  = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      s_nxt.rdy   = 1'b0;
      s_nxt.err   = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    s_r <= s_nxt;
  end

  // Outputs straight from the state
  assign prdata        = s_r.rdata;
  assign pready        = s_r.rdy;
  assign pslverr       = s_r.err;
  assign instr_pointer = s_r.ip;
  assign status_word   = {s_r.bank_select, s_r.cond_flags};
  assign gp_addr       = s_r.gpa;
  assign irq_take      = s_r.take;

  // Checks
  // One clock domain; reset mutes all but the reset checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Register writes in flight; a bus write beats core updates
  // Flag and pointer checks step aside for them, since software wins
  logic        wr_status;  // Status word written this edge
  logic        wr_ip;      // Pointer written this edge
  assign wr_status = wr_now && (paddr == crs_pkg::OFS_STATUS);
  assign wr_ip     = wr_now && (paddr == crs_pkg::OFS_IP);

  // Reset values, seen at the edge after reset is sampled
  // These keep their own disable so that reset itself is watched
  // Reset vector
  a_ip_reset_value: assert property (disable iff (1'b0) !reset_n |=> instr_pointer == crs_pkg::IP_RESET)
    else $error("pointer not at reset vector");
  a_reset_flag_bits: assert property (disable iff (1'b0) !reset_n |=> status_word[7:4] == 4'h3)
    else $error("reset enable or level wrong");
  // Bus and interrupt outputs quiet in reset
  a_reset_outs_quiet: assert property (disable iff (1'b0) !reset_n |=> !pready && !pslverr && !irq_take)
    else $error("outputs active after reset");

  // Pointer movement from the decoder
  // A load always beats a step in the same cycle
  // Step adds one
  a_ip_step_adds: assert property (ip_step && !ip_load && !wr_ip |=>
                                   instr_pointer == $past(instr_pointer) + 16'h0001)
    else $error("pointer step wrong");
  a_ip_load_value: assert property (ip_load && !wr_ip |=> instr_pointer == $past(ip_value))
    else $error("pointer load wrong");

  // Interrupt gating
  // Acceptance shows one cycle after the request is sampled
  // Disabled blocks service
  a_irq_enable_gate: assert property (irq_req && !status_word[crs_pkg::BIT_I] |=> !irq_take)
    else $error("interrupt taken while disabled");
  a_take_needs_req: assert property (!irq_req |=> !irq_take)
    else $error("take without request");
  a_irq_level_gate: assert property (irq_req && status_word[crs_pkg::BIT_I] && status_word[5:4] == 2'h3 &&
                                     irq_req_level == 2'h2 |=> irq_take)
    else $error("higher request not taken");
  a_top_level_holds: assert property (status_word[5:4] == crs_pkg::IL_TOP |=> !irq_take)
    else $error("request beat top level");
  a_irq_blank_code: assert property (status_word[5:4] == crs_pkg::IL_BLANK |=> !irq_take)
    else $error("blank level let request in");

  // Flags from byte operations; a status write beats them
  // Each flag is compared one cycle after the operation pulse
  // Zero flag
  a_zero_flag_set: assert property (alu_go && !wr_status && res == 8'h00 |=> status_word[crs_pkg::BIT_Z])
    else $error("zero flag missed");
  a_zero_flag_clear: assert property (alu_go && !wr_status && res != 8'h00 |=>
                                      !status_word[crs_pkg::BIT_Z])
    else $error("zero flag stuck");
  a_neg_flag_copy: assert property (alu_go && !wr_status |=> status_word[crs_pkg::BIT_N] == $past(res[7]))
    else $error("negative flag wrong");
  a_carry_add_out: assert property (alu_go && !alu_shift && !alu_sub && !wr_status &&
                                    opa == 8'hff && opb == 8'h01 |=> status_word[1:0] == 2'h1)
    else $error("carry from ff plus 01 wrong");
  a_sub_borrow_out: assert property (alu_go && alu_sub && !alu_shift && !wr_status &&
                                     opa == 8'h00 && opb == 8'h01 |=> status_word[crs_pkg::BIT_C])
    else $error("borrow from 00 minus 01 missed");
  a_shift_carry_out: assert property (alu_go && alu_shift && !wr_status |=>
                                      status_word[crs_pkg::BIT_C] == $past(opa[7]))
    else $error("shift carry wrong");
  // Shift has no nibble carry or signed overflow to report
  // Shift leaves H and V
  a_shift_keeps_hv: assert property (alu_go && alu_shift && !wr_status |=>
                                     status_word[crs_pkg::BIT_H] == $past(status_word[crs_pkg::BIT_H]) &&
                                     status_word[crs_pkg::BIT_V] == $past(status_word[crs_pkg::BIT_V]))
    else $error("shift changed half carry or overflow");
  a_half_carry_add: assert property (alu_go && !alu_shift && !alu_sub && !wr_status &&
                                     opa[3:0] == 4'hf && opb[3:0] == 4'h1 |=> status_word[crs_pkg::BIT_H])
    else $error("half carry missed");
  a_overflow_add: assert property (alu_go && !alu_shift && !alu_sub && !wr_status &&
                                   opa == 8'h7f && opb == 8'h01 |=> status_word[crs_pkg::BIT_V])
    else $error("overflow missed");

  // Bank addressing
  // Address follows the registered selector one cycle late
  // Address map
  a_bank_addr_map: assert property (##1 gp_addr == crs_pkg::GP_BASE + {5'h00, $past(status_word[12:8]),
                                    $past(reg_num)})
    else $error("bank address wrong");
  a_gp_addr_range: assert property (gp_addr >= crs_pkg::GP_BASE &&
                                    gp_addr <= crs_pkg::GP_BASE + 16'h00ff)
    else $error("bank address outside area");

  // Bus side
  // Status write lands whole
  a_status_write: assert property (wr_status |=> status_word == $past(pwdata[15:0]))
    else $error("status write lost");
  // Answer one cycle after setup
  a_apb_ready_next: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready timing wrong");
  // Ready stands one cycle
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  // Error only with ready
  a_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Upper read half is zero
  a_rdata_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  // Main scenarios
  c_irq_taken:   cover property (irq_take);
  c_sub_borrow:  cover property (alu_go && alu_sub && wide[8]);
  c_status_wr:   cover property (wr_status);
  c_bad_address: cover property (pready && pslverr);
  c_shift_op:    cover property (alu_go && alu_shift);

endmodule

/* dv/crs_issuer.sv */
// Decoder and ALU stand-in that issues requests to the register set
`timescale 1ns/1ps
module crs_issuer (
  // Clock
  input  wire logic        clock,
  // Requests to the register set
  output logic             alu_go,
  output logic             alu_sub,
  output logic             alu_shift,
  output logic             ip_step,
  output logic             ip_load,
  output logic [15:0]      ip_value
);
  // Idle at time zero
  initial begin
    alu_go = 1'b0;
    alu_sub = 1'b0;
    alu_shift = 1'b0;
    ip_step = 1'b0;
    ip_load = 1'b0;
    ip_value = 16'h0;
  end

  // One byte operation as a single cycle pulse
  task automatic alu_op(input logic sub, input logic sh);
    @(posedge clock);
    alu_go <= 1'b1;
    alu_sub <= sub;
    alu_shift <= sh;
    @(posedge clock);
    alu_go <= 1'b0;
  endtask

  // Pointer stepping for a number of cycles, optionally with a load
  task automatic step(input int n, input logic ld, input logic [15:0] v);
    @(posedge clock);
    ip_step <= 1'b1;
    ip_load <= ld;
    ip_value <= v;
    repeat (n) @(posedge clock);
    ip_step <= 1'b0;
    ip_load <= 1'b0;
  endtask
endmodule

/* dv/testbench.sv */
// Self-checking bench for the CPU register set
`timescale 1ns/1ps
module testbench;
  // Design ports
  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        alu_go, alu_sub, alu_shift, ip_step, ip_load, irq_req, irq_take;
  logic [15:0] ip_value, instr_pointer, status_word, gp_addr;
  logic [1:0]  irq_req_level;
  logic [2:0]  reg_num;
  // Bench state
  logic [31:0] rnd, rd;
  logic        er, e1;
  logic [7:0]  a, b, bank, flags;
  logic [8:0]  r;
  int          i, j, k, lv, miscompares, samples_checked;

  crs_core dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ip_step(ip_step), .ip_load(ip_load), .ip_value(ip_value), .alu_go(alu_go), .alu_sub(alu_sub),
    .alu_shift(alu_shift), .irq_req(irq_req), .irq_req_level(irq_req_level), .reg_num(reg_num),
    .instr_pointer(instr_pointer), .status_word(status_word), .gp_addr(gp_addr), .irq_take(irq_take));
  crs_issuer u_iss (.clock(clock), .alu_go(alu_go), .alu_sub(alu_sub), .alu_shift(alu_shift),
    .ip_step(ip_step), .ip_load(ip_load), .ip_value(ip_value));

  // Clock of 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Pseudo random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Verdict and end of run
  task automatic test_done();
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One compare with report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus transfer, bounded wait for the answer
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Main sequence
  initial begin
    {reset_n, psel, penable, pwrite, irq_req, irq_req_level, reg_num} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    rnd = 32'h02c3;
    flags = 8'h30;
    bank = 8'h0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    chk("instr_pointer", 32'hfffd, {16'h0, instr_pointer});
    chk("status_word", 32'h0030, {16'h0, status_word});
    apb(1'b0, crs_pkg::OFS_STATUS, 32'h0);
    chk("status_read", 32'h0030, rd);
    // Word registers round trip, upper half reads zero
    for (i = 1; i < 6; i++) begin
      rnd = lfsr(rnd);
      apb(1'b1, 8'(i * 4), rnd);
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("word_reg", {16'h0, rnd[15:0]}, rd);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    // Pointer wraps past the top, then a load beats a step
    u_iss.step(5, 1'b0, 16'h0);
    #1;
    chk("ip_step", 32'h0002, {16'h0, instr_pointer});
    rnd = lfsr(rnd);
    u_iss.step(2, 1'b1, rnd[15:0]);
    apb(1'b0, crs_pkg::OFS_IP, 32'h0);
    chk("ip_load", {16'h0, rnd[15:0]}, rd);
    // Byte operations against the flag model
    for (i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      a = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : (i == 3) ? 8'h7f : rnd[7:0];
      b = (i < 2 || i == 3) ? 8'h01 : rnd[15:8];
      k = (i < 3) ? i : (i == 3) ? 0 : rnd[17:16] % 3;
      apb(1'b1, crs_pkg::OFS_LHS, {16'h0, rnd[31:24], a});
      apb(1'b1, crs_pkg::OFS_RHS, {16'h0, rnd[23:16], b});
      r = (k == 2) ? {a, 1'b0} : (k == 1) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
      flags[0] = r[8];
      flags[3] = r[7];
      flags[2] = (r[7:0] == 8'h0);
      if (k != 2) begin
        flags[7] = (k == 1) ? (a[3:0] < b[3:0]) : ({1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0f);
        flags[1] = (k == 1) ? (a[7] != b[7]) && (r[7] != a[7]) : (a[7] == b[7]) && (r[7] != a[7]);
      end
      u_iss.alu_op(k == 1, k == 2);
      #1;
      chk("cond_flags", {16'h0, bank, flags}, {16'h0, status_word});
      apb(1'b0, crs_pkg::OFS_LHS, 32'h0);
      chk("lhs_byte", {16'h0, rnd[31:24], r[7:0]}, rd);
    end
    // Enable and level gating over every code, with bank addressing
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      bank = rnd[7:0];
      flags = {1'b0, i[2], i[1:0], 4'h0};
      lv = (i % 4 == 1) ? 0 : i % 4;
      apb(1'b1, crs_pkg::OFS_STATUS, {16'h0, bank, flags});
      apb(1'b0, crs_pkg::OFS_STATE, 32'h0);
      chk("state_reg", {17'h0, 2'(lv), 13'h0}, rd);
      reg_num <= rnd[10:8];
      for (j = 0; j < 4; j++) begin
        @(posedge clock);
        irq_req <= 1'b1;
        irq_req_level <= 2'(j);
        @(posedge clock);
        irq_req <= 1'b0;
        #1;
        e1 = (i >= 4) && (j < lv);
        chk("irq_take", {31'h0, e1}, {31'h0, irq_take});
      end
      chk("gp_addr", {16'h0, crs_pkg::GP_BASE + {8'h0, bank[4:0], rnd[10:8]}}, {16'h0, gp_addr});
      chk("status_word", {16'h0, bank, flags}, {16'h0, status_word});
    end
    test_done();
  end
endmodule
